// file: hw/bus_master_pkg.sv
// Constants for the expansion-bus master signalling block.
// Assumes a 20 MHz clock; all times converted to cycles here.
package bus_master_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TAKEOVER_LIMIT_NS = 7800;
    localparam int TAKEOVER_LIMIT_CYC = TAKEOVER_LIMIT_NS / CLK_PERIOD_NS;
    localparam int STREAM_PERIOD_NS = 100;
    localparam int STREAM_CYC = (STREAM_PERIOD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int ARB_SETTLE_CYC = 4;
    localparam int ARB_W = 4;
    // Cycle type code {memIo, s0, s1}
    localparam logic [2:0] CODE_IO_WR = 3'h1;
    localparam logic [2:0] CODE_IO_RD = 3'h2;
    localparam logic [2:0] CODE_IDLE = 3'h7;
    localparam logic [2:0] CODE_MEM_WR = 3'h5;
    localparam logic [2:0] CODE_MEM_RD = 3'h6;
    localparam logic [3:0] ARB_RESET_LEVEL = 4'hF;
endpackage

// file: hw/bus_master_ctrl.sv
// Bus ownership and cycle framing for the expansion-bus master side.
// Assumes external pull-ups on open-collector lines and a 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - While requesting, drive own level on arbitration lines and sample them.
// - Pull takeover line low while wanting bus; watch it for others.
// - Release bus within 7.8 us after another contender pulls takeover if no cycle is running; otherwise once that cycle ends.
// - Assert block-transfer request low whenever bus owner.
// - Pulse streaming strobe low on streaming write data as owner.
// - Sample streaming capability inputs as owner; support 100 ns streaming.
// - Never drive the streaming capability lines.
// - Drive address latch strobe as owner, receive it as slave; this block has no input for it and only drives it.
// - Drive command strobe for non-streaming cycles as owner.
// - Falling edge on a status line starts a cycle.
// - Cycle code {mem/io,s0,s1}: 001 IOW, 010 IOR, 101 MW, 110 MR, x11 idle.
// - Drive memory/IO select as owner, receive it as slave; this block has no input for it and only drives it.
// - Buffer direction output high only while owner.
module bus_master_ctrl (
    input wire logic clock,
    input wire logic rst,
    input wire logic busRequest,
    input wire logic [3:0] arbLevel,
    input wire logic cycleStart,
    input wire logic cycleIsMem,
    input wire logic cycleIsWrite,
    input wire logic cycleStream,
    input wire logic transferDone,
    input wire logic [3:0] arbitrationLevelLinesIn,
    input wire logic arbitrateOrGrantLine,
    input wire logic takeoverRequestIn,
    input wire logic [1:0] streamCapabilityInputs,
    output logic [3:0] arbitrationLevelLinesOe,
    output logic takeoverRequestOe,
    output logic blockTransferReqOe,
    output logic streamWriteStrobeN,
    output logic addressLatchStrobeN,
    output logic commandStrobeN,
    output logic [1:0] cycleStatusCode,
    output logic memIoSelect,
    output logic bufferDirectionControl,
    output logic busOwner,
    output logic cycleBusy,
    output logic [1:0] streamCapability
);
    //--------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------
    logic [3:0] arbMeta_q, arbSync_q;
    logic [1:0] grantMeta_q, takeMeta_q;
    logic grantSync_q, takeSync_q;
    logic [1:0] sdrMeta_q, sdrSync_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arbMeta_q <= 4'hF;
            arbSync_q <= 4'hF;
            grantMeta_q <= 2'h3;
            grantSync_q <= 1'b1;
            takeMeta_q <= 2'h3;
            takeSync_q <= 1'b1;
            sdrMeta_q <= 2'h3;
            sdrSync_q <= 2'h3;
        end else begin
            arbMeta_q <= arbitrationLevelLinesIn;
            arbSync_q <= arbMeta_q;
            grantMeta_q <= {1'b0, arbitrateOrGrantLine};
            grantSync_q <= grantMeta_q[0];
            takeMeta_q <= {1'b0, takeoverRequestIn};
            takeSync_q <= takeMeta_q[0];
            sdrMeta_q <= streamCapabilityInputs;
            sdrSync_q <= sdrMeta_q;
        end
    end

    //--------------------------------------------------------------
    // Ownership state machine
    //--------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARB = 4'h2,
        ST_OWN = 4'h4,
        ST_RELEASE = 4'h8
    } own_t;

    typedef enum logic [3:0] {
        CY_IDLE = 4'h1,
        CY_ADDR = 4'h2,
        CY_CMD = 4'h4,
        CY_END = 4'h8
    } cyc_t;

    own_t own_q, own_d;
    cyc_t cyc_q, cyc_d;
    logic [3:0] arbOe_q, arbOe_d;
    logic takeOe_q, takeOe_d;
    logic lost_q, lost_d;
    logic [8:0] preCnt_q, preCnt_d;
    logic preSeen_q, preSeen_d;
    logic adl_q, adl_d, cmd_q, cmd_d, sds_q, sds_d, dir_q, dir_d, burst_q;
    logic burst_d, mio_q, mio_d;
    logic [1:0] st_q, st_d, sdr_q, sdr_d;
    logic [2:0] code_q, code_d;
    logic strm_q, strm_d;
    logic [1:0] sCnt_q, sCnt_d;

    // Code {memIo,s0,s1} for a requested cycle
    function automatic logic [2:0] cycle_code(input logic mem,
                                              input logic wr);
        if (mem) begin
            cycle_code = wr ? bus_master_pkg::CODE_MEM_WR
                            : bus_master_pkg::CODE_MEM_RD;
        end else begin
            cycle_code = wr ? bus_master_pkg::CODE_IO_WR
                            : bus_master_pkg::CODE_IO_RD;
        end
    endfunction

    // Releasing also covers a contender pulling takeover while we own
    logic mustYield;
    assign mustYield = preSeen_q && (preCnt_q >= 9'(
        bus_master_pkg::TAKEOVER_LIMIT_CYC / 2));

    always_comb begin
        own_d = own_q;
        arbOe_d = arbOe_q;
        takeOe_d = takeOe_q;
        lost_d = lost_q;
        preSeen_d = preSeen_q;
        preCnt_d = preCnt_q;
        case (own_q)
            ST_IDLE: begin
                arbOe_d = 4'h0;
                lost_d = 1'b0;
                if (busRequest) begin
                    takeOe_d = 1'b1;
                    if (grantSync_q) begin
                        own_d = ST_ARB;
                    end
                end else begin
                    takeOe_d = 1'b0;
                end
            end
            ST_ARB: begin
                // Drive low bits of own level where it has a 0
                arbOe_d = ~arbLevel;
                if (grantSync_q) begin
                    // Mark lost once bit 3 of the lines is low where our level has a 1
                    if (arbSync_q[3] != arbLevel[3] && arbLevel[3]) begin
                        lost_d = 1'b1;
                    end
                end else begin
                    // Grant low: winner if lines match our level
                    if (!lost_q && arbSync_q == arbLevel) begin
                        own_d = ST_OWN;
                        takeOe_d = 1'b0;
                        preSeen_d = 1'b0;
                        preCnt_d = 9'h000;
                    end else begin
                        own_d = ST_IDLE;
                    end
                    arbOe_d = 4'h0;
                end
            end
            ST_OWN: begin
                if (!takeSync_q) begin
                    preSeen_d = 1'b1;
                end
                if (preSeen_q && preCnt_q != 9'h1FF) begin
                    preCnt_d = preCnt_q + 9'h001;
                end
                if (!busRequest || mustYield) begin
                    own_d = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (cyc_q == CY_IDLE) begin
                    own_d = ST_IDLE;
                end
            end
            default: own_d = ST_IDLE;
        endcase
    end

    //--------------------------------------------------------------
    // Cycle framing
    //--------------------------------------------------------------
    always_comb begin
        cyc_d = cyc_q;
        adl_d = 1'b1;
        cmd_d = 1'b1;
        sds_d = 1'b1;
        code_d = code_q;
        strm_d = strm_q;
        sCnt_d = sCnt_q;
        sdr_d = sdr_q;
        case (cyc_q)
            CY_IDLE: begin
                code_d = bus_master_pkg::CODE_IDLE;
                if (cycleStart && own_q == ST_OWN) begin
                    code_d = cycle_code(cycleIsMem, cycleIsWrite);
                    strm_d = cycleStream && cycleIsWrite
                             && sdrSync_q != 2'h3;
                    sdr_d = sdrSync_q;
                    adl_d = 1'b0;
                    cyc_d = CY_ADDR;
                end
            end
            CY_ADDR: begin
                cyc_d = CY_CMD;
                sCnt_d = 2'h0;
            end
            CY_CMD: begin
                if (strm_q) begin
                    // Strobe low on first half of each 100 ns beat
                    sds_d = (sCnt_q == 2'h0) ? 1'b0 : 1'b1;
                    sCnt_d = (sCnt_q == 2'(bus_master_pkg::STREAM_CYC - 1))
                             ? 2'h0 : sCnt_q + 2'h1;
                end else begin
                    cmd_d = 1'b0;
                end
                if (transferDone) begin
                    cmd_d = 1'b1;
                    sds_d = 1'b1;
                    cyc_d = CY_END;
                end
            end
            CY_END: begin
                code_d = bus_master_pkg::CODE_IDLE;
                strm_d = 1'b0;
                cyc_d = CY_IDLE;
            end
            default: cyc_d = CY_IDLE;
        endcase
        {mio_d, st_d} = code_d;
        dir_d = (own_d == ST_OWN) || (own_d == ST_RELEASE);
        burst_d = dir_d;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            own_q <= ST_IDLE;
            cyc_q <= CY_IDLE;
            arbOe_q <= 4'h0;
            takeOe_q <= 1'b0;
            lost_q <= 1'b0;
            preSeen_q <= 1'b0;
            preCnt_q <= 9'h000;
            adl_q <= 1'b1;
            cmd_q <= 1'b1;
            sds_q <= 1'b1;
            code_q <= bus_master_pkg::CODE_IDLE;
            mio_q <= 1'b1;
            st_q <= 2'h3;
            strm_q <= 1'b0;
            sCnt_q <= 2'h0;
            sdr_q <= 2'h3;
            dir_q <= 1'b0;
            burst_q <= 1'b0;
        end else begin
            own_q <= own_d;
            cyc_q <= cyc_d;
            arbOe_q <= arbOe_d;
            takeOe_q <= takeOe_d;
            lost_q <= lost_d;
            preSeen_q <= preSeen_d;
            preCnt_q <= preCnt_d;
            adl_q <= adl_d;
            cmd_q <= cmd_d;
            sds_q <= sds_d;
            code_q <= code_d;
            mio_q <= mio_d;
            st_q <= st_d;
            strm_q <= strm_d;
            sCnt_q <= sCnt_d;
            sdr_q <= sdr_d;
            dir_q <= dir_d;
            burst_q <= burst_d;
        end
    end

    // Streaming capability lines are inputs only; no enable exists
    assign arbitrationLevelLinesOe = arbOe_q;
    assign takeoverRequestOe = takeOe_q;
    assign blockTransferReqOe = burst_q;
    assign streamWriteStrobeN = sds_q;
    assign addressLatchStrobeN = adl_q;
    assign commandStrobeN = cmd_q;
    assign cycleStatusCode = st_q;
    assign memIoSelect = mio_q;
    assign bufferDirectionControl = dir_q;
    assign busOwner = dir_q;
    assign cycleBusy = (cyc_q != CY_IDLE);
    assign streamCapability = sdr_q;

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    property p_yield;
        @(posedge clock) disable iff (rst)
        $fell(takeSync_q) && own_q == ST_OWN && cyc_q == CY_IDLE
        |-> ##[1:160] !dir_q;
    endproperty
    a_yield: assert property (p_yield)
        else $error("owner did not release after takeover");

    property p_dir;
        @(posedge clock) disable iff (rst)
        !dir_q |-> addressLatchStrobeN && commandStrobeN;
    endproperty
    a_dir: assert property (p_dir)
        else $error("framing driven while not owner");

    property p_burst;
        @(posedge clock) disable iff (rst)
        blockTransferReqOe == bufferDirectionControl;
    endproperty
    a_burst: assert property (p_burst)
        else $error("block request not tied to ownership");

    sequence s_adl;
        !addressLatchStrobeN ##1 addressLatchStrobeN;
    endsequence
    property p_frame;
        @(posedge clock) disable iff (rst)
        $fell(addressLatchStrobeN) |-> ({memIoSelect, cycleStatusCode}
            != bus_master_pkg::CODE_IDLE) and s_adl;
    endproperty
    a_frame: assert property (p_frame)
        else $error("cycle code not active at latch strobe");

    property p_take;
        @(posedge clock) disable iff (rst)
        own_q == ST_ARB |-> takeoverRequestOe;
    endproperty
    a_take: assert property (p_take)
        else $error("takeover not driven while arbitrating");

    property p_arb;
        @(posedge clock) disable iff (rst)
        own_q == ST_ARB ##1 own_q == ST_ARB |-> arbOe_q == ~arbLevel;
    endproperty
    a_arb: assert property (p_arb)
        else $error("arbitration level not driven");

    property p_cmd;
        @(posedge clock) disable iff (rst)
        !commandStrobeN |-> streamWriteStrobeN && !strm_q;
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("command strobe during streaming");

    property p_sds;
        @(posedge clock) disable iff (rst)
        !streamWriteStrobeN |-> dir_q && strm_q;
    endproperty
    a_sds: assert property (p_sds)
        else $error("stream strobe outside streaming write");
endmodule

`default_nettype wire

// file: sim/bus_arbiter_model.sv
// Behavioural central arbiter plus one rival master for the bus master block.
// Assumes pull-ups on arbitration, grant and takeover lines.
`timescale 1ns/10ps
`default_nettype none
module bus_arbiter_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] dutArbOe,
    input wire logic dutTakeoverOe,
    input wire logic dutBurstOe,
    input wire logic rivalReq,
    input wire logic [3:0] rivalLevel,
    input wire logic [7:0] arbLen,
    output logic [3:0] arbLines,
    output logic grantLine,
    output logic takeoverLine
);
    logic [7:0] arbCount_q;
    logic [7:0] guard_q;
    logic grant_q;
    // ----------------------------------------
    // Open-collector lines
    // ----------------------------------------
    assign arbLines = ~(dutArbOe | (rivalReq ? ~rivalLevel : 4'h0));
    assign takeoverLine = ~(dutTakeoverOe | rivalReq);
    assign grantLine = grant_q;
    // Guard lets the winner assert its burst line before a new contest
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            grant_q <= 1'b0;
            arbCount_q <= 8'h00;
            guard_q <= 8'h00;
        end else if (arbCount_q != 8'h00) begin
            arbCount_q <= arbCount_q - 8'h01;
            grant_q <= (arbCount_q != 8'h01);
            guard_q <= 8'h10;
        end else if (guard_q != 8'h00) begin
            guard_q <= guard_q - 8'h01;
        end else if (!takeoverLine && !dutBurstOe) begin
            arbCount_q <= arbLen;
            grant_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the expansion-bus master signalling block.
// Assumes the package, design and arbiter model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clock, rst, busRequest, cycleStart, cycleIsMem, cycleIsWrite;
    logic cycleStream, transferDone, grantLine, takeoverLine, rivalReq;
    logic takeoverOe, burstOe, sdStrobeN, adlN, cmdN, memIo, dirOut;
    logic owner, busy, seen, askSeen;
    logic [3:0] arbLevel, arbLines, arbOe, rivalLevel;
    logic [1:0] streamCap, statusCode, capSeen;
    logic [7:0] arbLen;
    int errCount, checked, n;
    logic [2:0] codes [4] = '{bus_master_pkg::CODE_IO_WR,
        bus_master_pkg::CODE_IO_RD, bus_master_pkg::CODE_MEM_WR,
        bus_master_pkg::CODE_MEM_RD};
    bus_master_ctrl uut (.clock(clock), .rst(rst), .busRequest(busRequest),
        .arbLevel(arbLevel), .cycleStart(cycleStart), .cycleIsMem(cycleIsMem),
        .cycleIsWrite(cycleIsWrite), .cycleStream(cycleStream),
        .transferDone(transferDone), .arbitrationLevelLinesIn(arbLines),
        .arbitrateOrGrantLine(grantLine), .takeoverRequestIn(takeoverLine),
        .streamCapabilityInputs(streamCap), .arbitrationLevelLinesOe(arbOe),
        .takeoverRequestOe(takeoverOe), .blockTransferReqOe(burstOe),
        .streamWriteStrobeN(sdStrobeN), .addressLatchStrobeN(adlN),
        .commandStrobeN(cmdN), .cycleStatusCode(statusCode),
        .memIoSelect(memIo), .bufferDirectionControl(dirOut),
        .busOwner(owner), .cycleBusy(busy), .streamCapability(capSeen));
    bus_arbiter_model farSide (.clock(clock), .rst(rst), .dutArbOe(arbOe),
        .dutTakeoverOe(takeoverOe), .dutBurstOe(burstOe),
        .rivalReq(rivalReq), .rivalLevel(rivalLevel), .arbLen(arbLen),
        .arbLines(arbLines), .grantLine(grantLine),
        .takeoverLine(takeoverLine));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [3:0] got, input logic [3:0] exp,
            input string what);
        checked++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: %s got %h want %h", $time, what,
                got, exp);
        end
    endtask
    task automatic waitLevel(ref logic s, input logic lvl, input int lim);
        n = 0;
        while (s !== lvl && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
        check({3'h0, s}, {3'h0, lvl}, "bounded wait");
    endtask
    task automatic finishTest;
        $display("checks %0d mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic testReset;
        check({adlN, cmdN, sdStrobeN, dirOut}, 4'hE, "idle strobes");
        check({1'b0, memIo, statusCode}, 4'h7, "idle code");
        check({2'h0, burstOe, takeoverOe}, 4'h0, "idle pulls");
        $display("reset test done");
    endtask
    task automatic testAcquire(input logic [7:0] len);
        @(posedge clock);
        busRequest <= 1'b1;
        arbLen <= len;
        cycleStart <= 1'b1;
        @(posedge clock);
        cycleStart <= 1'b0;
        seen = 1'b0;
        askSeen = 1'b0;
        n = 0;
        while (owner !== 1'b1 && n < 150) begin
            @(posedge clock);
            #1;
            n++;
            seen = seen | (arbOe === ~arbLevel);
            askSeen = askSeen | (takeoverOe === 1'b1);
            if (owner !== 1'b1) check({1'b0, adlN, cmdN, dirOut}, 4'h6,
                "framing before grant");
        end
        check({2'h0, seen, askSeen}, 4'h3, "contest pulls");
        check({3'h0, grantLine}, 4'h0, "grant at ownership");
        check({2'h0, dirOut, burstOe}, 4'h3, "owner outputs");
        $display("acquire test done");
    endtask
    task automatic runCycle(input logic [2:0] code, input logic strm,
            input logic [3:0] lowsExp);
        logic [3:0] lows;
        lows = 4'h0;
        @(posedge clock);
        cycleStart <= 1'b1;
        cycleIsMem <= code[2];
        cycleIsWrite <= ~code[1];
        cycleStream <= strm;
        @(posedge clock);
        cycleStart <= 1'b0;
        #1;
        waitLevel(adlN, 1'b0, 3);
        check({1'b0, code}, {1'b0, memIo, statusCode}, "code");
        check({2'h0, capSeen}, {2'h0, streamCap}, "capability");
        @(posedge clock);
        #1;
        check({3'h0, adlN}, 4'h1, "latch strobe width");
        repeat (8) begin
            @(posedge clock);
            #1;
            lows = lows + {3'h0, ~sdStrobeN};
        end
        check({3'h0, cmdN}, {3'h0, lowsExp != 4'h0}, "command");
        check(lows, lowsExp, "stream strobes");
        @(posedge clock);
        transferDone <= 1'b1;
        @(posedge clock);
        transferDone <= 1'b0;
        #1;
        waitLevel(busy, 1'b0, 5);
        check({memIo, statusCode, cmdN}, 4'hF, "cycle end");
    endtask
    task automatic testCycles;
        for (int i = 0; i < 4; i++) begin
            runCycle(codes[i], 1'b0, 4'h0);
        end
        @(posedge clock);
        streamCap <= 2'h2;
        repeat (3) @(posedge clock);
        runCycle(bus_master_pkg::CODE_MEM_WR, 1'b1, 4'h4);
        @(posedge clock);
        streamCap <= 2'h3;
        repeat (3) @(posedge clock);
        runCycle(bus_master_pkg::CODE_MEM_WR, 1'b1, 4'h0);
        $display("cycle tests done");
    endtask
    task automatic testPreempt;
        @(posedge clock);
        rivalReq <= 1'b1;
        n = 0;
        while (owner === 1'b1 && n < 300) begin
            @(posedge clock);
            #1;
            n++;
        end
        check({3'h0, n <= bus_master_pkg::TAKEOVER_LIMIT_CYC}, 4'h1,
            "yield time");
        check({2'h0, dirOut, burstOe}, 4'h0, "yielded outputs");
        @(posedge clock);
        busRequest <= 1'b0;
        rivalReq <= 1'b0;
        repeat (30) @(posedge clock);
        $display("preempt test done");
    endtask
    task automatic testRelease;
        @(posedge clock);
        busRequest <= 1'b0;
        #1;
        waitLevel(dirOut, 1'b0, 10);
        check({1'b0, burstOe, takeoverOe, owner}, 4'h0, "released");
        $display("release test done");
    endtask
    // ----------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        rst = 1'b1;
        {busRequest, cycleStart, cycleIsMem, cycleIsWrite} = 4'h0;
        {cycleStream, transferDone, rivalReq} = 3'h0;
        arbLevel = 4'h5;
        rivalLevel = 4'h1;
        streamCap = 2'h3;
        arbLen = 8'h04;
        errCount = 0;
        checked = 0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        testReset;
        testAcquire(8'h04);
        testCycles;
        testPreempt;
        testAcquire(8'h18);
        testRelease;
        finishTest;
    end
    initial begin
        repeat (20000) @(posedge clock);
        errCount++;
        $display("wrong value at %0t: watchdog expired", $time);
        finishTest;
    end
endmodule
`default_nettype wire
